// *** design/input_phase_sync_reformatter.sv ***
// Link capture, phase retiming, calibration, crossing pipeline and reformatting.
//
// Overview of operation
// - Four 10-bit channels in, ten serial outputs.
// - Word is eight data, parity, crossing flag.
// - Data split into nibbles, control bits paired.
// - Each channel captured on its forwarded clock.
// - Captured words cross through intermediate retiming stage.
// - Per-channel retiming phase, four quadrature choices.
// - Phase from slow control or calibration.
// - Start pulse begins the phase search.
// - Calibration tries all phases, counts pattern errors.
// - Fewest-error phase chosen per channel.
// - Calibration-complete output high after all channels.
// - Calibrated phases readable, later write replaces.
// - Per-channel one-word delay, slow control only.
// - Parity checked over data and flag.
// - Readout word carries parity-error in parity position.
// - Parity errors counted; error output when nonzero.
// - Lock-lost output is OR of unlock indications.
// - Data-available output for readout register.
// - Readout address generated locally.
// - Reset clears flags, empty data, link ready.
// - Pipeline shifts every system clock edge.
// - Empty word is nine bits, MSB only.
`timescale 1ns/10ps
`default_nettype none

module ro_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wp_r;
   logic [PW-1:0] rp_r;
   logic [PW:0] cnt_r;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
      $error("FIFO depth must be a power of two, at least two");
   end

   // Full and empty come straight from the fill count.
   assign in_ready = (cnt_r != PW'(0) + (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointers and count.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + PW'(1);
         if (pop) rp_r <= rp_r + PW'(1);
         cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   // Storage has no reset; only written slots are ever read.
   always_ff @(posedge mclk) begin
      if (push) mem[wp_r] <= in_data;
   end
endmodule

module input_phase_sync_reformatter
   import phase_sync_pkg::*;
#(
   parameter int CAL_LEN = phase_sync_pkg::CAL_WORDS
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [phase_sync_pkg::NCH-1:0] link_clk,
   input wire logic [phase_sync_pkg::NCH*phase_sync_pkg::WORD_W-1:0] link_data,
   input wire logic [phase_sync_pkg::NCH-1:0] link_unlock,
   input wire logic cal_start,
   input wire logic phase_wr,
   input wire logic [phase_sync_pkg::NCH*phase_sync_pkg::PHASE_W-1:0] phase_wdata,
   input wire logic [phase_sync_pkg::NCH-1:0] delay_en,
   input wire logic perr_clr,
   input wire logic ro_ready,
   output logic [phase_sync_pkg::NCH*phase_sync_pkg::PHASE_W-1:0] phase_rd,
   output logic cal_busy,
   output logic cal_done,
   output logic [phase_sync_pkg::NSER-1:0] ser_out,
   output logic ser_frame,
   output logic lock_lost,
   output logic perr_flag,
   output logic [phase_sync_pkg::PERR_W-1:0] perr_count,
   output logic ro_avail,
   output logic [phase_sync_pkg::RO_W-1:0] ro_word,
   output logic [phase_sync_pkg::ADDR_W-1:0] ro_addr
);
   import phase_sync_pkg::*;

   if (CAL_LEN < 2 || CAL_LEN >= (1 << CAL_CNT_W)) begin : g_chk
      $error("CAL_LEN out of range for the calibration counter");
   end

   // Two nibbles of data per channel, control nibble per pair.
   function automatic logic [5*NIB_W-1:0] pair_nibbles(input logic [WORD_W-1:0] wa,
                                                       input logic [WORD_W-1:0] wb);
      pair_nibbles = {wb[FLAG_POS], wb[PAR_POS], wa[FLAG_POS], wa[PAR_POS],
                      wb[DATA_W-1:0], wa[DATA_W-1:0]};
   endfunction

   // ------------------------------------------------------------
   // Per-channel capture and retiming
   // ------------------------------------------------------------
   logic [NCH*PHASE_W-1:0] phase_r;
   logic [PHASE_W-1:0] cal_ph_r;
   cal_state_t cal_st_r;
   logic [NCH-1:0] ret_v;
   logic [WORD_W-1:0] ret_w [NCH];
   logic [WORD_W-1:0] sys_w [NCH];
   logic [NCH-1:0] cap_v;

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [2:0] clk_s_r;
      logic [WORD_W-1:0] d_s1_r;
      logic [WORD_W-1:0] d_s2_r;
      logic [WORD_W-1:0] cap_r;
      logic [PHASE_W-1:0] cnt_r;
      logic armed_r;
      logic [WORD_W-1:0] ret_r;
      logic ret_v_r;
      logic [WORD_W-1:0] dly_r;
      logic [WORD_W-1:0] sys_r;
      logic [PHASE_W-1:0] sel;

      // Forwarded clock and data pass two flops before use; edges come from
      // the second and third flops so the first is never looked at.
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            clk_s_r <= '0;
            d_s1_r <= '0;
            d_s2_r <= '0;
         end else begin
            clk_s_r <= {clk_s_r[1:0], link_clk[c]};
            d_s1_r <= link_data[c*WORD_W +: WORD_W];
            d_s2_r <= d_s1_r;
         end
      end
      assign cap_v[c] = clk_s_r[1] && !clk_s_r[2];

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) cap_r <= '0;
         else if (cap_v[c]) cap_r <= d_s2_r;
      end

      assign sel = (cal_st_r == CAL_RUN) ? cal_ph_r : phase_r[c*PHASE_W +: PHASE_W];

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            cnt_r <= '0;
            armed_r <= 1'b0;
            ret_r <= '0;
            ret_v_r <= 1'b0;
         end else begin
            ret_v_r <= 1'b0;
            if (cap_v[c]) begin
               cnt_r <= '0;
               armed_r <= 1'b1;
            end else if (armed_r) begin
               if (cnt_r == sel) begin
                  ret_r <= cap_r;
                  ret_v_r <= 1'b1;
                  armed_r <= 1'b0;
               end else begin
                  cnt_r <= cnt_r + PHASE_W'(1);
               end
            end
         end
      end
      assign ret_v[c] = ret_v_r;
      assign ret_w[c] = ret_r;

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            dly_r <= '0;
            sys_r <= '0;
         end else if (ret_v_r) begin
            dly_r <= ret_r;
            sys_r <= delay_en[c] ? dly_r : ret_r;
         end
      end
      assign sys_w[c] = sys_r;
   end

   // ------------------------------------------------------------
   // Automatic phase calibration
   // ------------------------------------------------------------
   logic start_s1_r;
   logic start_s2_r;
   logic start_s3_r;
   logic start_p;
   logic [CAL_CNT_W-1:0] wcnt_r;
   logic [NCH-1:0] prev_ok_r;
   logic [WORD_W-1:0] prev_w_r [NCH];
   logic [ERR_W-1:0] err_r [NCH];
   logic [ERR_W-1:0] best_err_r [NCH];
   logic [NCH*PHASE_W-1:0] best_ph_r;
   logic trial_end;

   // Start pin is treated as coming from outside the clock domain.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         start_s1_r <= 1'b0;
         start_s2_r <= 1'b0;
         start_s3_r <= 1'b0;
      end else begin
         start_s1_r <= cal_start;
         start_s2_r <= start_s1_r;
         start_s3_r <= start_s2_r;
      end
   end
   assign start_p = start_s2_r && !start_s3_r;
   assign trial_end = (cal_st_r == CAL_RUN) && ret_v[0] && (wcnt_r == CAL_CNT_W'(CAL_LEN - 1));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cal_st_r <= CAL_IDLE;
         cal_ph_r <= '0;
         wcnt_r <= '0;
      end else begin
         unique case (cal_st_r)
            CAL_IDLE: begin
               if (start_p) begin
                  cal_st_r <= CAL_RUN;
                  cal_ph_r <= '0;
                  wcnt_r <= '0;
               end
            end
            CAL_RUN: begin
               if (ret_v[0]) wcnt_r <= trial_end ? '0 : wcnt_r + CAL_CNT_W'(1);
               if (trial_end) begin
                  cal_ph_r <= cal_ph_r + PHASE_W'(1);
                  if (cal_ph_r == PHASE_W'(NPHASE - 1)) cal_st_r <= CAL_PICK;
               end
            end
            CAL_PICK: cal_st_r <= CAL_IDLE;
         endcase
      end
   end

   // error counting and best phase per channel
   for (genvar c = 0; c < NCH; c++) begin : g_cal
      logic bad;
      assign bad = !((ret_w[c] == ALL_HIGH && prev_w_r[c] == ALL_LOW) ||
                     (ret_w[c] == ALL_LOW && prev_w_r[c] == ALL_HIGH));
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            prev_ok_r[c] <= 1'b0;
            prev_w_r[c] <= '0;
            err_r[c] <= '0;
            best_err_r[c] <= '1;
            best_ph_r[c*PHASE_W +: PHASE_W] <= '0;
         end else if (cal_st_r == CAL_IDLE) begin
            prev_ok_r[c] <= 1'b0;
            err_r[c] <= '0;
            best_err_r[c] <= '1;
         end else if (cal_st_r == CAL_RUN) begin
            if (trial_end) begin
               // Strictly fewer errors wins, so ties keep the earlier phase.
               if (err_r[c] < best_err_r[c]) begin
                  best_err_r[c] <= err_r[c];
                  best_ph_r[c*PHASE_W +: PHASE_W] <= cal_ph_r;
               end
               err_r[c] <= '0;
               prev_ok_r[c] <= 1'b0;
            end else if (ret_v[c]) begin
               prev_w_r[c] <= ret_w[c];
               prev_ok_r[c] <= 1'b1;
               if (prev_ok_r[c] && bad && err_r[c] != '1) err_r[c] <= err_r[c] + ERR_W'(1);
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) phase_r <= PHASE_RST;
      else if (cal_st_r == CAL_PICK) phase_r <= best_ph_r;
      else if (phase_wr) phase_r <= phase_wdata;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cal_done <= 1'b0;
         cal_busy <= 1'b0;
         phase_rd <= PHASE_RST;
      end else begin
         cal_busy <= (cal_st_r != CAL_IDLE);
         if (cal_st_r == CAL_PICK) cal_done <= 1'b1;
         else if (start_p) cal_done <= 1'b0;
         phase_rd <= phase_r;
      end
   end

   // ------------------------------------------------------------
   // Crossing pipeline and parity
   // ------------------------------------------------------------
   logic tick_r;
   logic stage_v_r;
   logic [NCH-1:0] unlock_s1_r;
   logic [NCH-1:0] unlock_s2_r;
   logic [NCH-1:0] earlier_flag_stage_r;
   logic [NCH-1:0] crossing_flag_stage_r;
   logic [SLOT_W-1:0] data_stage_r [NCH];
   logic [NCH-1:0] link_ok_stage_r;
   logic [NCH-1:0] perr;

   // Channel 0 paces the word slots; other slots carry the empty word.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_r <= 1'b0;
         stage_v_r <= 1'b0;
         unlock_s1_r <= '0;
         unlock_s2_r <= '0;
      end else begin
         tick_r <= ret_v[0];
         stage_v_r <= tick_r;
         unlock_s1_r <= link_unlock;
         unlock_s2_r <= unlock_s1_r;
      end
   end

   for (genvar c = 0; c < NCH; c++) begin : g_pipe
      logic incoming_flag;
      logic [SLOT_W-1:0] data_next;
      assign incoming_flag = tick_r ? sys_w[c][FLAG_POS] : 1'b0;
      assign data_next = tick_r ? sys_w[c][SLOT_W-1:0] : EMPTY_WORD;
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            earlier_flag_stage_r[c] <= 1'b0;
            crossing_flag_stage_r[c] <= 1'b0;
            data_stage_r[c] <= EMPTY_WORD;
            link_ok_stage_r[c] <= LINK_READY;
         end else begin
            earlier_flag_stage_r[c] <= crossing_flag_stage_r[c];
            crossing_flag_stage_r[c] <= incoming_flag;
            data_stage_r[c] <= data_next;
            link_ok_stage_r[c] <= tick_r ? !unlock_s2_r[c] : LINK_READY;
         end
      end
      // odd parity over data, flag and parity bit
      assign perr[c] = ~^{crossing_flag_stage_r[c], data_stage_r[c]};
   end

   // error counter and lock-lost output; a new error beats a clear.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         perr_count <= '0;
         perr_flag <= 1'b0;
         lock_lost <= 1'b0;
      end else begin
         lock_lost <= |unlock_s2_r;
         if (stage_v_r && perr != '0) begin
            if (perr_count != '1) perr_count <= perr_count + PERR_W'(1);
            perr_flag <= 1'b1;
         end else if (perr_clr) begin
            perr_count <= '0;
            perr_flag <= 1'b0;
         end else begin
            perr_flag <= (perr_count != '0);
         end
      end
   end

   // ------------------------------------------------------------
   // Nibble reformatting and serial outputs
   // ------------------------------------------------------------
   logic [NIB_W-1:0] shreg_r [NSER];
   logic [NCH*WORD_W-1:0] stage_words;

   for (genvar c = 0; c < NCH; c++) begin : g_sw
      assign stage_words[c*WORD_W +: WORD_W] = {crossing_flag_stage_r[c], data_stage_r[c]};
   end

   // load nibbles per slot, shift one bit per clock
   for (genvar s = 0; s < NSER; s++) begin : g_ser
      localparam int PAIR = s / 5;
      localparam int NIB = s % 5;
      logic [5*NIB_W-1:0] nibs;
      assign nibs = pair_nibbles(stage_words[(2*PAIR)*WORD_W +: WORD_W],
                                 stage_words[(2*PAIR+1)*WORD_W +: WORD_W]);
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            shreg_r[s] <= '0;
            ser_out[s] <= 1'b0;
         end else begin
            ser_out[s] <= stage_v_r ? nibs[NIB*NIB_W] : shreg_r[s][1];
            shreg_r[s] <= stage_v_r ? nibs[NIB*NIB_W +: NIB_W] : {1'b0, shreg_r[s][NIB_W-1:1]};
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) ser_frame <= 1'b0;
      else ser_frame <= stage_v_r;
   end

   // ------------------------------------------------------------
   // Readout path
   // ------------------------------------------------------------
   logic pend_v_r;
   logic [RO_W-1:0] pend_w_r;
   logic f_in_ready;
   logic f_out_valid;
   logic [RO_W-1:0] f_out_data;
   logic f_pop;

   // parity position replaced by error marker. A full FIFO holds the
   // pending word and later slot-0 words are skipped until it drains.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_v_r <= 1'b0;
         pend_w_r <= '0;
      end else if (!pend_v_r || f_in_ready) begin
         pend_v_r <= stage_v_r;
         pend_w_r <= {link_ok_stage_r[0], perr[0], data_stage_r[0][DATA_W-1:0]};
      end
   end

   ro_fifo #(.WIDTH(RO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(pend_v_r),
      .in_ready(f_in_ready),
      .in_data(pend_w_r),
      .out_valid(f_out_valid),
      .out_ready(f_pop),
      .out_data(f_out_data)
   );

   // registered readout stage with local address
   assign f_pop = f_out_valid && (!ro_avail || ro_ready);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ro_avail <= 1'b0;
         ro_word <= '0;
         ro_addr <= '0;
      end else begin
         if (ro_avail && ro_ready) ro_addr <= ro_addr + ADDR_W'(1);
         if (!ro_avail || ro_ready) begin
            ro_avail <= f_out_valid;
            ro_word <= f_out_data;
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_cal_begin;
      start_p && cal_st_r == CAL_IDLE;
   endsequence
   sequence s_running;
      cal_st_r == CAL_RUN;
   endsequence
   // Channel 0 stays on phase three with nothing able to move its selector.
   sequence s_phase3_quiet;
      !phase_wr && !start_p && cal_st_r == CAL_IDLE && phase_r[1:0] == 2'h3;
   endsequence

   a_cal_start_run: assert property (@(posedge mclk) disable iff (!rst_n)
      s_cal_begin |=> s_running ##1 cal_busy) else $error("calibration did not start");
   a_cal_done_set: assert property (@(posedge mclk) disable iff (!rst_n)
      cal_st_r == CAL_PICK |=> cal_done && phase_r == $past(best_ph_r))
      else $error("calibration end did not store phases");
   a_phase_write: assert property (@(posedge mclk) disable iff (!rst_n)
      phase_wr && cal_st_r != CAL_PICK |=> ##1 phase_rd == $past(phase_wdata, 2))
      else $error("phase write not readable");
   // The strobe comes one cycle after the load, then three counted cycles, then one more.
   a_retime_bound: assert property (@(posedge mclk) disable iff (!rst_n)
      cap_v[0] ##0 s_phase3_quiet[*4] |-> ##2 ret_v[0])
      else $error("retime strobe late for phase three");
   a_pipe_shift: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 earlier_flag_stage_r == $past(crossing_flag_stage_r))
      else $error("flag pipeline did not shift");
   a_empty_slot: assert property (@(posedge mclk) disable iff (!rst_n)
      !tick_r |=> data_stage_r[1] == EMPTY_WORD && !crossing_flag_stage_r[1])
      else $error("idle slot not empty");
   a_perr_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      stage_v_r && perr != '0 |=> perr_flag && perr_count != '0)
      else $error("parity error not flagged");
   a_lock_or: assert property (@(posedge mclk) disable iff (!rst_n)
      ##3 lock_lost == |$past(link_unlock, 3)) else $error("lock lost mismatch");
   a_ro_addr_step: assert property (@(posedge mclk) disable iff (!rst_n)
      ro_avail && ro_ready |=> ro_addr == $past(ro_addr) + ADDR_W'(1))
      else $error("readout address did not advance");
   // The enabled delay hands on the word before the one just retimed.
   a_delay_stage: assert property (@(posedge mclk) disable iff (!rst_n)
      ret_v[0] |=> sys_w[0] == ($past(delay_en[0]) ? $past(g_ch[0].dly_r) : $past(ret_w[0])))
      else $error("delay stage picked the wrong word");
endmodule

`default_nettype wire

// *** pkg/phase_sync_pkg.sv ***
// Constants, field layouts and reset values shared by the input front end.
package phase_sync_pkg;
   // ------------------------------------------------------------
   // Channel and word layout
   // ------------------------------------------------------------
   localparam int NCH = 4;
   localparam int WORD_W = 10;
   localparam int DATA_W = 8;
   localparam int SLOT_W = 9;
   localparam int FLAG_POS = 9;
   localparam int PAR_POS = 8;
   localparam int PHASE_W = 2;
   localparam int NPHASE = 4;
   localparam int NSER = 10;
   localparam int NIB_W = 4;
   // ------------------------------------------------------------
   // Reset values and patterns
   // ------------------------------------------------------------
   localparam logic [SLOT_W-1:0] EMPTY_WORD = 9'h100;
   localparam logic LINK_READY = 1'b1;
   localparam logic [WORD_W-1:0] ALL_HIGH = 10'h3FF;
   localparam logic [WORD_W-1:0] ALL_LOW = 10'h000;
   localparam logic [NCH*PHASE_W-1:0] PHASE_RST = 8'h00;
   // ------------------------------------------------------------
   // Counts
   // ------------------------------------------------------------
   localparam int CAL_WORDS = 16;
   localparam int CAL_CNT_W = 5;
   localparam int ERR_W = 8;
   localparam int PERR_W = 16;
   localparam int ADDR_W = 7;
   localparam int FIFO_DEPTH = 4;
   localparam int RO_W = 10;
   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_PICK} cal_state_t;
endpackage

// *** test/link_source.sv ***
// Behavioural model of the four link de-serialisers feeding the front end.
`timescale 1ns/10ps
`default_nettype none

module link_source
   import phase_sync_pkg::*;
(
   output logic [phase_sync_pkg::NCH-1:0] link_clk,
   output logic [phase_sync_pkg::NCH*phase_sync_pkg::WORD_W-1:0] link_data,
   input wire logic toggle,
   input wire logic [phase_sync_pkg::WORD_W-1:0] word
);
   // ---------------------------------------------------------------
   // Per-channel forwarded clock and word
   // ---------------------------------------------------------------
   // Channel 0 rises last, so the other channels are never later than it.
   // forwarded word clock
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic ph_r;
      initial begin
         ph_r = 1'b0;
         link_clk[c] = 1'b0;
         link_data[c*WORD_W+:WORD_W] = ALL_LOW;
         #(37 - 7 * c);
         forever begin
            #200 link_clk[c] = 1'b1;
            #200 link_clk[c] = 1'b0;
            ph_r = ~ph_r;
            link_data[c*WORD_W+:WORD_W] = toggle ? (ph_r ? ALL_HIGH : ALL_LOW) : word;
         end
      end
   end
endmodule
`default_nettype wire

// *** test/input_phase_sync_reformatter_tb_top.sv ***
// Self-checking bench for the input phase sync and reformatting front end.
`timescale 1ns/10ps
`default_nettype none

module input_phase_sync_reformatter_tb_top;
   import phase_sync_pkg::*;
   localparam int CAL_SHORT = 4;
   logic mclk = 1'b0;
   logic rst_n, cal_start, phase_wr, perr_clr, ro_ready, toggle;
   logic cal_busy, cal_done, ser_frame, lock_lost, perr_flag, ro_avail, busy_seen;
   logic [NCH-1:0] link_clk, link_unlock, delay_en, uv;
   logic [NCH*WORD_W-1:0] link_data;
   logic [NCH*PHASE_W-1:0] phase_wdata, phase_rd, wv;
   logic [WORD_W-1:0] word;
   logic [NSER-1:0] ser_out;
   logic [NSER-1:0] so [8];
   logic [PERR_W-1:0] perr_count;
   logic [RO_W-1:0] ro_word;
   logic [ADDR_W-1:0] ro_addr, addr0;
   logic [7:0] d;
   int n_mismatch, comparisons, i;

   // Tick runs freely; the link side keeps its own unrelated phase.
   always #25 mclk = ~mclk;

   input_phase_sync_reformatter #(.CAL_LEN(CAL_SHORT)) input_phase_sync_reformatter_i (
      .mclk, .rst_n, .link_clk, .link_data, .link_unlock, .cal_start, .phase_wr,
      .phase_wdata, .delay_en, .perr_clr, .ro_ready, .phase_rd, .cal_busy, .cal_done,
      .ser_out, .ser_frame, .lock_lost, .perr_flag, .perr_count, .ro_avail, .ro_word,
      .ro_addr);
   link_source link_source_i (.link_clk, .link_data, .toggle, .word);

   // ---------------------------------------------------------------
   // Expectations, comparison and closing
   // ---------------------------------------------------------------
   // Odd parity over all ten bits with the crossing flag left low.
   function automatic logic [WORD_W-1:0] mk_word(input logic [7:0] v, input logic bad);
      return {1'b0, ~(^v) ^ bad, v};
   endfunction
   // A nibble may land in either half of the captured window.
   function automatic logic hit(input int b, input logic [3:0] e);
      logic [7:0] s;
      for (int k = 0; k < 8; k++) s[k] = so[k][b];
      return (s[3:0] == e) || (s[7:4] == e);
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic give_up(input logic ok);
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED wait expected 1 seen 0");
         complete_run();
      end
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst_n, cal_start, phase_wr, perr_clr, ro_ready, toggle} = 6'h00;
      {phase_wdata, link_unlock, delay_en} = 16'h0000;
      word = mk_word(8'h00, 1'b0);
      n_mismatch = 0;
      comparisons = 0;
      void'($urandom(72109));
      tick(4);
      rst_n <= 1'b1;
      tick(2);
      chk("cal_done", 16'h0, 16'(cal_done));
      chk("perr_flag", 16'h0, 16'(perr_flag));
      // Four writes four cycles apart, each read back, the last one a fixed corner value.
      for (i = 0; i < 4; i++) begin
         wv = (i == 3) ? 8'hE4 : 8'($urandom);
         phase_wr <= 1'b1;
         phase_wdata <= wv;
         tick(1);
         phase_wr <= 1'b0;
         tick(3);
         chk("phase_rd", 16'(wv), 16'(phase_rd));
      end
      $display("test phase write done");
      for (i = 0; i < 4; i++) begin
         uv = (i == 0) ? 4'h8 : (i == 3) ? 4'h0 : 4'($urandom);
         link_unlock <= uv;
         tick(6);
         chk("lock_lost", 16'(|uv), 16'(lock_lost));
      end
      $display("test lock done");
      toggle <= 1'b1;
      tick(24);
      cal_start <= 1'b1;
      tick(2);
      cal_start <= 1'b0;
      busy_seen = 1'b0;
      for (i = 0; i < 3000 && cal_done !== 1'b1; i++) begin
         busy_seen |= (cal_busy === 1'b1);
         tick(1);
      end
      give_up(cal_done);
      chk("cal_busy seen", 16'h1, 16'(busy_seen));
      tick(2);
      // Clean pattern: every phase ties, the lowest wins on all channels.
      chk("phase_rd cal", 16'h0000, 16'(phase_rd));
      phase_wr <= 1'b1;
      phase_wdata <= 8'h1B;
      tick(1);
      phase_wr <= 1'b0;
      tick(3);
      chk("phase_rd over", 16'h001B, 16'(phase_rd));
      $display("test calibration done");
      d = 8'($urandom) | 8'h11;
      toggle <= 1'b0;
      word <= mk_word(d, 1'b0);
      delay_en <= 4'($urandom);
      ro_ready <= 1'b1;
      tick(48);
      perr_clr <= 1'b1;
      tick(1);
      perr_clr <= 1'b0;
      tick(3);
      chk("perr_count", 16'h0, perr_count);
      for (i = 0; i < 100 && ser_frame !== 1'b1; i++) tick(1);
      give_up(ser_frame);
      for (i = 0; i < 8; i++) begin
         so[i] = ser_out;
         tick(1);
      end
      chk("ser lo", 16'h1, 16'(hit(0, d[3:0]) && hit(5, d[3:0])));
      chk("ser hi", 16'h1, 16'(hit(1, d[7:4]) && hit(6, d[7:4])));
      chk("ser ctl", 16'h1, 16'(hit(4, {1'b0, ~(^d), 1'b0, ~(^d)})));
      chk("ser lo b", 16'h1, 16'(hit(2, d[3:0]) && hit(7, d[3:0])));
      chk("ser hi b", 16'h1, 16'(hit(3, d[7:4]) && hit(8, d[7:4])));
      chk("ser ctl b", 16'h1, 16'(hit(9, {1'b0, ~(^d), 1'b0, ~(^d)})));
      $display("test serial done");
      word <= mk_word(d, 1'b1);
      tick(40);
      ro_ready <= 1'b0;
      tick(48);
      chk("perr_flag", 16'h1, 16'(perr_flag));
      chk("perr_count nz", 16'h1, 16'(perr_count != 16'h0));
      chk("ro_avail", 16'h1, 16'(ro_avail));
      chk("ro_word", 16'({2'b11, d}), 16'(ro_word));
      addr0 = ro_addr;
      ro_ready <= 1'b1;
      tick(1);
      ro_ready <= 1'b0;
      tick(3);
      chk("ro_addr", 16'(addr0 + 7'h01), 16'(ro_addr));
      $display("test readout done");
      complete_run();
   end
endmodule
`default_nettype wire
